// [pkg/brightness_defs.svh]
/*
 * Constants of the serial-only brightness mapper: register offsets,
 * field positions, reset values and scaling figures.
 * Assumes it is included by bare name wherever these values are needed.
 */
// Overview of operation
// - Serial-only current control runs only when enable bit 0 is one, simple-enable bit 7 is zero and PWM-enable bit 5 is zero.
// - With PWM-enable cleared the duty cycle at the PWM pin takes no part in the LED current setpoint.
// - In serial-only mode the setpoint is the full-scale current from bits [4:2] times the brightness fraction, with no duty factor.
// - Configuration bit 1 picks the mapping, zero for the exponential table and one for the linear law.
// - A full-scale field of 101 gives a full-scale LED current of 22.5 mA.
// - In exponential mapping code 0x72 gives 48.438 percent of full scale, and every code follows the exponential table.
// - In linear mapping code 0x72 gives 89.76 percent of full scale.
// - After reset the mapping-select bit reads zero, so exponential mapping holds until software changes it.
`ifndef BRIGHTNESS_DEFS_SVH
`define BRIGHTNESS_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define GEN_CFG_ADDR     8'h10
`define BRIGHT_ADDR      8'hA0
`define GEN_CFG_RST      8'h00
`define BRIGHT_RST       7'h00
`define DEV_ADDR_DEF     7'h38

// ----------------------------------------------------------------
// General configuration fields
// ----------------------------------------------------------------
`define CFG_EN_BIT       0
`define CFG_MAP_BIT      1
`define CFG_FS_LSB       2
`define CFG_FS_MSB       4
`define CFG_PWM_EN_BIT   5
`define CFG_POL_BIT      6
`define CFG_SIMPLE_BIT   7

// ----------------------------------------------------------------
// Scaling: full scale in 0.1 mA, fraction in 0.001 percent
// ----------------------------------------------------------------
`define FS_BASE_TENTH_MA 9'h032
`define FS_STEP_TENTH_MA 9'h023
`define FRAC_FULL        17'h186A0
`define LIN_DIV          24'h00007F
`define UA_DIV           26'h00003E8
`define SETPOINT_W       16

`endif

// [pkg/brightness_pkg.sv]
/*
 * Types of the serial-only brightness mapper: bus states and the
 * packed state record of the top module.
 * Assumes brightness_defs.svh is on the include path.
 */
`include "brightness_defs.svh"

package brightness_pkg;

   // ----------------------------------------------------------------
   // Serial bus slave states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX   = 5'h02,
      ST_ACK  = 5'h04,
      ST_TX   = 5'h08,
      ST_MACK = 5'h10
   } bus_state_e;

   // Meaning of the byte being received
   typedef enum logic [1:0] {
      KIND_ADDR = 2'h0,
      KIND_PTR  = 2'h1,
      KIND_DATA = 2'h2
   } byte_kind_e;

   // ----------------------------------------------------------------
   // Whole state of the top module
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                    scl_m;
      logic                    scl_s;
      logic                    scl_p;
      logic                    sda_m;
      logic                    sda_s;
      logic                    sda_p;
      bus_state_e              st;
      byte_kind_e              kind;
      logic [3:0]              bit_cnt;
      logic [7:0]              shreg;
      logic [7:0]              ptr;
      logic                    is_read;
      logic                    sda_out;
      logic                    sda_oe;
      logic [7:0]              gen_cfg;
      logic [6:0]              bright;
      logic [`SETPOINT_W-1:0]  setpoint;
      logic                    active;
   } mapper_state_s;

endpackage : brightness_pkg

// [verilog/brightness_table.sv]
/*
 * Brightness code to fraction of full scale, in 0.001 percent units.
 * Purely combinational; assumes the caller registers the result.
 */
`include "brightness_defs.svh"

module brightness_table (
   // Code and mapping choice
   input  wire logic [6:0]  code,
   input  wire logic        linear,
   // Fraction of full scale
   output logic      [16:0] frac
);

   // ----------------------------------------------------------------
   // Exponential table, measured figures kept as printed
   // ----------------------------------------------------------------
   localparam logic [16:0] EXP_TAB [128] = '{
      17'd0,     17'd80,    17'd86,    17'd94,    17'd102,   17'd109,   17'd117,   17'd125,
      17'd133,   17'd141,   17'd148,   17'd156,   17'd164,   17'd172,   17'd180,   17'd188,
      17'd203,   17'd211,   17'd227,   17'd242,   17'd250,   17'd266,   17'd281,   17'd297,
      17'd320,   17'd336,   17'd352,   17'd375,   17'd398,   17'd422,   17'd445,   17'd469,
      17'd500,   17'd523,   17'd555,   17'd586,   17'd617,   17'd656,   17'd695,   17'd734,
      17'd773,   17'd820,   17'd867,   17'd914,   17'd969,   17'd1031,  17'd1078,  17'd1148,
      17'd1219,  17'd1281,  17'd1359,  17'd1430,  17'd1523,  17'd1594,  17'd1688,  17'd1781,
      17'd1898,  17'd2016,  17'd2109,  17'd2250,  17'd2367,  17'd2508,  17'd2648,  17'd2789,
      17'd2953,  17'd3125,  17'd3336,  17'd3500,  17'd3719,  17'd3906,  17'd4141,  17'd4375,
      17'd4648,  17'd4922,  17'd5195,  17'd5469,  17'd5781,  17'd6125,  17'd6484,  17'd6875,
      17'd7266,  17'd7656,  17'd8047,  17'd8594,  17'd9063,  17'd9609,  17'd10078, 17'd10781,
      17'd11250, 17'd11953, 17'd12656, 17'd13359, 17'd14219, 17'd15000, 17'd15859, 17'd16875,
      17'd17813, 17'd18750, 17'd19922, 17'd20859, 17'd22266, 17'd23438, 17'd24844, 17'd26250,
      17'd27656, 17'd29297, 17'd31172, 17'd32813, 17'd34453, 17'd35547, 17'd38828, 17'd41016,
      17'd43203, 17'd45938, 17'd48438, 17'd51406, 17'd54141, 17'd57031, 17'd60703, 17'd63984,
      17'd67813, 17'd71875, 17'd75781, 17'd79688, 17'd84375, 17'd89844, 17'd94531, 17'd100000
   };

   // ----------------------------------------------------------------
   // Linear law: code over 127 of full scale
   // ----------------------------------------------------------------
   logic [23:0] lin_prod;
   logic [23:0] lin_frac;

   assign lin_prod = 24'({17'h00000, code}) * 24'(`FRAC_FULL);
   assign lin_frac = lin_prod / `LIN_DIV;

   // Code zero gives zero in both, since both laws start at zero
   assign frac = linear ? lin_frac[16:0] : EXP_TAB[code];

endmodule : brightness_table

// [verilog/serial_only_brightness_mapper.sv]
/*
 * Serial-only brightness mapper: a two-wire register slave holding the
 * general configuration and the brightness code, and the setpoint
 * arithmetic for the LED current regulator.
 * Assumes scl and sda come from pins with external pull-ups, and that
 * the regulator reads the setpoint as microamps.
 */
`include "brightness_defs.svh"

module serial_only_brightness_mapper #(
   parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEF   // Arbitrary default
) (
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // Two-wire bus pins
   input  wire logic                   scl_in,
   input  wire logic                   sda_in,
   output logic                        sda_out,
   output logic                        sda_oe,
   // Regulator side
   output logic [`SETPOINT_W-1:0]      led_current_setpoint,
   output logic                        serial_only_active
);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   // Reserved address groups would collide with general call and friends
   if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_bad_addr
      $error("DEV_ADDR falls in a reserved address group");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam brightness_pkg::mapper_state_s RESET_STATE = '{
      scl_m    : 1'b1,
      scl_s    : 1'b1,
      scl_p    : 1'b1,
      sda_m    : 1'b1,
      sda_s    : 1'b1,
      sda_p    : 1'b1,
      st       : brightness_pkg::ST_IDLE,
      kind     : brightness_pkg::KIND_ADDR,
      bit_cnt  : 4'h0,
      shreg    : 8'h00,
      ptr      : 8'h00,
      is_read  : 1'b0,
      sda_out  : 1'b0,
      sda_oe   : 1'b0,
      gen_cfg  : `GEN_CFG_RST,
      bright   : `BRIGHT_RST,
      setpoint : '0,
      active   : 1'b0
   };

   brightness_pkg::mapper_state_s q;
   brightness_pkg::mapper_state_s d;

   // ----------------------------------------------------------------
   // Register read decode
   // ----------------------------------------------------------------
   // Unmapped offsets read as zero; brightness bit 7 always reads zero
   function automatic logic [7:0] reg_read(input logic [7:0] addr,
                                           input logic [7:0] cfg,
                                           input logic [6:0] bright);
      logic [7:0] val;
      val = 8'h00;
      case (addr)
         `GEN_CFG_ADDR: val = cfg;
         `BRIGHT_ADDR:  val = {1'b0, bright};
         default:       val = 8'h00;
      endcase
      return val;
   endfunction : reg_read

   // ----------------------------------------------------------------
   // Bus events from the synchronised pins
   // ----------------------------------------------------------------
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   assign scl_rise  = q.scl_s & ~q.scl_p;
   assign scl_fall  = ~q.scl_s & q.scl_p;
   assign bus_start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
   assign bus_stop  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

   // ----------------------------------------------------------------
   // Setpoint arithmetic
   // ----------------------------------------------------------------
   logic [16:0] frac;
   logic [8:0]  fs_tenth_ma;
   logic [25:0] sp_prod;
   logic [25:0] sp_ua;
   logic        mode_ok;

   brightness_table u_table (
      .code   (q.bright),
      .linear (q.gen_cfg[`CFG_MAP_BIT]),
      .frac   (frac)
   );

   // Full scale grows in equal steps with the three-bit field
   assign fs_tenth_ma = `FS_BASE_TENTH_MA
                      + 9'(`FS_STEP_TENTH_MA * q.gen_cfg[`CFG_FS_MSB:`CFG_FS_LSB]);

   // Only full scale and fraction; the PWM pin is not even wired in
   assign sp_prod = 26'(fs_tenth_ma) * 26'(frac);
   assign sp_ua   = sp_prod / `UA_DIV;

   assign mode_ok = q.gen_cfg[`CFG_EN_BIT]
                  & ~q.gen_cfg[`CFG_SIMPLE_BIT]
                  & ~q.gen_cfg[`CFG_PWM_EN_BIT];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      // Two flops per pin, a third copy for edge detection
      d.scl_m = scl_in;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = sda_in;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      d.sda_out = 1'b0;

      if (bus_start) begin
         // A repeated start also lands here and restarts addressing
         d.st      = brightness_pkg::ST_RX;
         d.kind    = brightness_pkg::KIND_ADDR;
         d.bit_cnt = 4'h0;
         d.sda_oe  = 1'b0;
      end else if (bus_stop) begin
         d.st     = brightness_pkg::ST_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         case (q.st)
            brightness_pkg::ST_IDLE: begin
               d.sda_oe = 1'b0;
            end
            brightness_pkg::ST_RX: begin
               if (scl_rise && q.bit_cnt != 4'h8) begin
                  d.shreg   = {q.shreg[6:0], q.sda_s};
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end else if (scl_fall && q.bit_cnt == 4'h8) begin
                  d.st     = brightness_pkg::ST_ACK;
                  d.sda_oe = 1'b1;
                  case (q.kind)
                     brightness_pkg::KIND_ADDR: begin
                        d.is_read = q.shreg[0];
                        if (q.shreg[7:1] != DEV_ADDR) begin
                           // Not ours: release the bus and wait for a start
                           d.st     = brightness_pkg::ST_IDLE;
                           d.sda_oe = 1'b0;
                        end
                     end
                     brightness_pkg::KIND_PTR: begin
                        d.ptr = q.shreg;
                     end
                     default: begin
                        // Writes to unmapped offsets are dropped
                        if (q.ptr == `GEN_CFG_ADDR) begin
                           d.gen_cfg = q.shreg;
                        end
                        if (q.ptr == `BRIGHT_ADDR) begin
                           d.bright = q.shreg[6:0];
                        end
                        d.ptr = q.ptr + 8'h01;
                     end
                  endcase
               end
            end
            brightness_pkg::ST_ACK: begin
               if (scl_fall) begin
                  d.bit_cnt = 4'h0;
                  if (q.kind == brightness_pkg::KIND_ADDR && q.is_read) begin
                     d.shreg  = reg_read(q.ptr, q.gen_cfg, q.bright);
                     d.sda_oe = ~d.shreg[7];
                     d.ptr    = q.ptr + 8'h01;
                     d.st     = brightness_pkg::ST_TX;
                  end else begin
                     d.sda_oe = 1'b0;
                     d.st     = brightness_pkg::ST_RX;
                     d.kind   = (q.kind == brightness_pkg::KIND_ADDR)
                              ? brightness_pkg::KIND_PTR : brightness_pkg::KIND_DATA;
                  end
               end
            end
            brightness_pkg::ST_TX: begin
               if (scl_fall) begin
                  d.bit_cnt = q.bit_cnt + 4'h1;
                  if (q.bit_cnt == 4'h7) begin
                     d.sda_oe = 1'b0;
                     d.st     = brightness_pkg::ST_MACK;
                  end else begin
                     d.shreg  = {q.shreg[6:0], 1'b0};
                     d.sda_oe = ~q.shreg[6];
                  end
               end
            end
            brightness_pkg::ST_MACK: begin
               // A not-acknowledge ends the read burst
               if (scl_rise && q.sda_s) begin
                  d.st = brightness_pkg::ST_IDLE;
               end else if (scl_fall) begin
                  d.bit_cnt = 4'h0;
                  d.shreg   = reg_read(q.ptr, q.gen_cfg, q.bright);
                  d.sda_oe  = ~d.shreg[7];
                  d.ptr     = q.ptr + 8'h01;
                  d.st      = brightness_pkg::ST_TX;
               end
            end
            default: begin
               d.st     = brightness_pkg::ST_IDLE;
               d.sda_oe = 1'b0;
            end
         endcase
      end

      // Other control modes are outside this block, so they read zero
      d.active   = mode_ok;
      d.setpoint = mode_ok ? sp_ua[`SETPOINT_W-1:0] : '0;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Mapping bit resets to zero so exponential mapping starts in force
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign sda_out              = q.sda_out;
   assign sda_oe               = q.sda_oe;
   assign led_current_setpoint = q.setpoint;
   assign serial_only_active   = q.active;

endmodule : serial_only_brightness_mapper

// [verification/serial_only_brightness_mapper_chk.sv]
/*
 * Port checker of the brightness mapper, bound to the top module.
 * Assumes clk_sys at 40 MHz and bus phases of eight clocks or more.
 */
`include "brightness_defs.svh"

module serial_only_brightness_mapper_chk (
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // Bus pins
   input  wire logic                   scl_in,
   input  wire logic                   sda_in,
   input  wire logic                   sda_out,
   input  wire logic                   sda_oe,
   // Regulator side
   input  wire logic [`SETPOINT_W-1:0] led_current_setpoint,
   input  wire logic                   serial_only_active
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [3:0] hi_q;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Run length of a high bus clock, saturating so it never wraps
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hi_q <= 4'h0;
      end else begin
         hi_q <= !scl_in ? 4'h0 : ((hi_q == 4'hF) ? hi_q : hi_q + 4'h1);
      end
   end

   a_reset_quiet: assert property ($fell(rst) |-> !sda_oe && !serial_only_active
      && led_current_setpoint == '0) else $error("outputs not clear after reset");
   a_sda_low_only: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_off_no_current: assert property (!serial_only_active |-> led_current_setpoint == '0)
      else $error("current while not serial-only");
   a_sp_ceiling: assert property (led_current_setpoint <= 16'h733C)
      else $error("setpoint above top full scale");
   a_steady_high: assert property (hi_q >= 4'h8 |-> $stable(led_current_setpoint)
      && $stable(serial_only_active)) else $error("setpoint moved with bus clock high");
   a_change_low: assert property ($changed(led_current_setpoint)
      || $changed(serial_only_active) |-> !scl_in && !$past(scl_in))
      else $error("setpoint moved outside a low bus clock");
   a_sp_stands: assert property ($changed(led_current_setpoint)
      |=> $stable(led_current_setpoint)[*4]) else $error("setpoint glitched");
   a_ack_holds: assert property ($rose(sda_oe) |-> sda_oe[*8])
      else $error("bus drive cut short");
   a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("bus drive changed with clock high");

   // Main scenarios reached
   c_active: cover property ($rose(serial_only_active));
   c_ack: cover property ($rose(sda_oe));
   c_example: cover property (serial_only_active && led_current_setpoint == 16'h2A92);

endmodule : serial_only_brightness_mapper_chk

bind serial_only_brightness_mapper serial_only_brightness_mapper_chk u_chk (
   .clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .led_current_setpoint(led_current_setpoint),
   .serial_only_active(serial_only_active));

// [verification/bus_host_model.sv]
/*
 * Host on the two-wire register bus: start, stop, bytes and whole
 * register write and read sequences, called by the testbench.
 * Assumes sda_line is the resolved pin level with a pull-up.
 */
module bus_host_model (
   // Clock
   input  wire logic clk_sys,
   // Bus pins
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_pull
);
   timeunit 1ns;
   timeprecision 100ps;

   int half = 8;  // Clocks per phase; raise it for a slow host

   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // One phase, then step just past the clock edge
   task automatic tick;
      repeat (half) @(posedge clk_sys);
      #2;
   endtask : tick

   // Data moves only with scl low; sampled at the end of the high phase
   task automatic bit_io(input logic d, output logic q);
      tick;
      sda_pull = !d;
      tick;
      scl = 1'b1;
      tick;
      q = sda_line;
      scl = 1'b0;
   endtask : bit_io

   // Also serves as repeated start
   task automatic start;
      sda_pull = 1'b0;
      tick;
      scl = 1'b1;
      tick;
      sda_pull = 1'b1;
      tick;
      scl = 1'b0;
   endtask : start

   task automatic stop;
      tick;
      sda_pull = 1'b1;
      tick;
      scl = 1'b1;
      tick;
      sda_pull = 1'b0;
      tick;
   endtask : stop

   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], q);
      end
      bit_io(1'b1, q);
      ack = !q;
   endtask : put_byte

   // Register write; ok is low if any byte went unanswered
   task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                     output logic ok);
      logic a0;
      logic a1;
      logic a2;
      start;
      put_byte({dev, 1'b0}, a0);
      put_byte(ptr, a1);
      put_byte(d, a2);
      stop;
      ok = a0 & a1 & a2;
   endtask : wr

   // Register read: pointer, repeated start, one byte, then no-ack
   task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d);
      logic a;
      start;
      put_byte({dev, 1'b0}, a);
      put_byte(ptr, a);
      start;
      put_byte({dev, 1'b1}, a);
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(1'b1, a);
      stop;
   endtask : rd

endmodule : bus_host_model

// [verification/serial_only_brightness_mapper_test.sv]
/*
 * Self-checking bench of the brightness mapper: the host model reaches
 * the registers, a reference model predicts setpoint and mode.
 * Assumes the checker is compiled with it and binds itself.
 */
`include "brightness_defs.svh"

module serial_only_brightness_mapper_test;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [6:0] DEV = 7'h2B;  // Arbitrary bus address
   logic                   clk_sys;
   logic                   rst;
   logic                   scl;
   logic                   sda_pull;
   logic                   sda_out;
   logic                   sda_oe;
   logic                   active;
   logic [`SETPOINT_W-1:0] setpoint;
   wire logic              sda_line;
   int                     err_total;
   int                     checks;
   logic [31:0]            rnd;
   logic [7:0]             cfg_m;
   int                     bright_m;
   logic                   ok;
   // Exponential table points and their fractions in 0.001 percent
   int ecode [8] = '{7'h00, 7'h01, 7'h1D, 7'h40, 7'h60, 7'h72, 7'h7D, 7'h7F};
   int eval [8] = '{17'h0, 17'h50, 17'h1A6, 17'hB89, 17'h4595, 17'hBD36, 17'h15EF4, 17'h186A0};
   logic [7:0] combo [5] = '{8'h95, 8'h35, 8'h14, 8'h55, 8'h01};

   // Open-drain data line with pull-up
   assign sda_line = !(sda_pull || sda_oe);

   serial_only_brightness_mapper #(.DEV_ADDR(DEV)) u_dut (.clk_sys(clk_sys), .rst(rst),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .led_current_setpoint(setpoint), .serial_only_active(active));
   bus_host_model u_host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
      .sda_pull(sda_pull));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // ------------------------------------------------------------
   // Reference model and helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   // Only table codes are asked for in exponential mode
   function automatic int model_sp(input logic [7:0] cfg, input int code);
      int frac;
      frac = code * `FRAC_FULL / `LIN_DIV;
      for (int i = 0; i < 8; i++) begin
         if (!cfg[1] && ecode[i] == code) frac = eval[i];
      end
      if (!cfg[0] || cfg[5] || cfg[7]) return 0;
      return (`FS_BASE_TENTH_MA + `FS_STEP_TENTH_MA * cfg[4:2]) * frac / `UA_DIV;
   endfunction : model_sp

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Write a register, then compare the regulator side with the model
   task automatic put(input logic [7:0] ptr, input logic [7:0] d);
      u_host.wr(DEV, ptr, d, ok);
      chk(16'(ok), 16'h0001);
      if (ptr == `GEN_CFG_ADDR) cfg_m = d;
      if (ptr == `BRIGHT_ADDR) bright_m = int'(d[6:0]);
      chk(setpoint, 16'(model_sp(cfg_m, bright_m)));
      chk(16'(active), 16'(cfg_m[0] & !cfg_m[5] & !cfg_m[7]));
   endtask : put

   task automatic get(input logic [7:0] ptr, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(DEV, ptr, d);
      chk(16'(d), 16'(exp));
   endtask : get

   task automatic wrap_up;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      err_total = 0;
      checks = 0;
      rnd = 32'h0000B62C;
      cfg_m = 8'h00;
      bright_m = 0;
      repeat (8) @(posedge clk_sys);
      #2;
      rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      get(`GEN_CFG_ADDR, 8'h00);
      get(`BRIGHT_ADDR, 8'h00);
      put(`BRIGHT_ADDR, 8'h72);
      put(`GEN_CFG_ADDR, 8'h15);
      chk(setpoint, 16'h2A92);
      put(`GEN_CFG_ADDR, 8'h17);
      chk(setpoint, 16'h4EE4);
      foreach (combo[i]) put(`GEN_CFG_ADDR, combo[i]);
      put(`GEN_CFG_ADDR, 8'h15);
      foreach (ecode[i]) put(`BRIGHT_ADDR, 8'(ecode[i]));
      put(`GEN_CFG_ADDR, 8'h1F);
      put(`BRIGHT_ADDR, 8'hFF);
      get(`BRIGHT_ADDR, 8'h7F);
      put(`BRIGHT_ADDR, 8'h00);
      // Unmapped offset takes the write and reads back empty
      put(8'h20, 8'h55);
      get(8'h20, 8'h00);
      // Foreign address is ignored
      u_host.wr(DEV ^ 7'h01, `GEN_CFG_ADDR, 8'h00, ok);
      chk(16'(ok), 16'h0000);
      get(`GEN_CFG_ADDR, cfg_m);
      u_host.half = 20;
      put(`GEN_CFG_ADDR, 8'h11);
      u_host.half = 8;
      for (int n = 0; n < 12; n++) begin
         rnd = xs(rnd);
         // Table code first, so a switch to exponential stays predictable
         put(`BRIGHT_ADDR, 8'(ecode[rnd[10:8]]));
         put(`GEN_CFG_ADDR, {1'b0, rnd[6], 1'b0, rnd[4:1], 1'b1});
         if (cfg_m[1]) put(`BRIGHT_ADDR, {1'b0, rnd[14:8]});
      end
      // Second reset in mid-run clears the mapping choice
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #2;
      rst = 1'b0;
      cfg_m = 8'h00;
      bright_m = 0;
      repeat (4) @(posedge clk_sys);
      #2;
      chk(setpoint, 16'h0000);
      get(`GEN_CFG_ADDR, 8'h00);
      wrap_up;
   end

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk_sys);
      err_total++;
      $display("BAD t=%0t run too long", $time);
      wrap_up;
   end

endmodule : serial_only_brightness_mapper_test
